// *** hw/paired_channel_pwm.sv ***
// paired channel pwm: master interval timer sets the period, slave one-count timer sets the duty
// assumes a plain register port on ref_clk and an outside port cell that resolves level and enable
//
// Function
// R1: period is (period reload value + 1) count clocks.
// R2: duty is duty reload value over (period reload value + 1), in percent; equal duty and period reload values give full duty here.
// R3: duty reload value zero keeps the output inactive.
// R4: duty reload value at least period plus one keeps the output active.
// R5: master start trigger raises a tick at once, loads, then counts down.
// R6: master counter at zero raises a tick, reloads and keeps counting.
// R7: master keeps cycling until its stop trigger is written with one.
// R8: each master tick loads the duty counter, which then counts down.
// R9: duty counter at zero raises its interrupt and halts until the next tick.
// R10: output turns active one count clock after the master tick.
// R11: output turns inactive when the duty counter reaches zero.
// R12: software rewrites all reload values right after a master tick.
// R13: in 8-bit use software writes zero to the reload upper byte.
// R14: power enable low stops the clock and blocks register access.
// R15: prescaler select sets both prescaled count clock rates.
// R16: slave output mode bit makes tick set and count end clear.
// R17: pin stays high-impedance until the port is configured.
// R18: output level shows when port direction is output, latch zero.
// R19: stopped channels leave the output level unchanged.
// R20: start and stop trigger bits read back zero, self-clearing.
// R21: stop clears running flags, freezes counters, holds the output.
// R22: polarity bit selects an active-high or active-low output.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "pwm_defs.svh"

module paired_channel_pwm
	import pwm_pkg::*;
(
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	// register port
	input  wire logic [`PWM_ADDR_W-1:0] addr,
	input  wire logic [`PWM_DATA_W-1:0] wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output logic      [`PWM_DATA_W-1:0] rdata,
	// events
	output logic                       period_tick_irq,
	output logic                       duty_end_irq,
	// pwm pin
	output logic                       pwm_out,
	output logic                       pwm_oe
);

	bus_req_s req;

	// register state
	logic                       power_reg;
	logic [2*`PWM_SEL_W-1:0]    prescaler_select_reg;
	logic                       channel_mode_reg;
	out_ctrl_s                  out_ctrl_reg;
	logic [1:0]                 port_reg;
	logic [`PWM_DATA_W-1:0]     period_reload_value;
	logic [`PWM_DATA_W-1:0]     duty_reload_value;
	logic [`PWM_DATA_W-1:0]     rdata_reg;
	logic [`PWM_DATA_W-1:0]     rdata_next;

	// channel state
	logic [1:0]                 channel_running_flag;
	logic [`PWM_DATA_W-1:0]     period_counter;
	logic [`PWM_DATA_W-1:0]     period_counter_next;
	logic [`PWM_DATA_W-1:0]     duty_counter;
	logic [`PWM_DATA_W-1:0]     duty_counter_next;
	slave_state_e               slave_state_reg;
	slave_state_e               slave_state_next;
	logic                       level_reg;
	logic                       level_next;

	// decoded strobes and events
	logic                       acc_ok;
	logic                       wr_power;
	logic                       wr_any;
	logic                       wr_start;
	logic                       wr_stop;
	logic                       wr_level;
	logic                       period_start_trigger;
	logic                       duty_start_trigger;
	logic                       period_stop_trigger;
	logic                       duty_stop_trigger;
	logic                       tick_a;
	logic                       tick_b;
	logic                       count_en;
	logic                       master_zero;
	logic                       master_step;
	logic                       master_tick;
	logic                       slave_step;
	logic                       slave_end;
	logic                       slave_rise;
	logic                       slave_retrigger;
	logic                       hw_owns_level;
	pin_s                       pin;

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// offset compare shared by the write decode and the read mux
	function automatic logic hit(input logic [`PWM_ADDR_W-1:0] a, input logic [`PWM_ADDR_W-1:0] off);
		return a == off;
	endfunction

	// one step down; callers test for zero first so it never wraps
	function automatic logic [`PWM_DATA_W-1:0] count_down(input logic [`PWM_DATA_W-1:0] v);
		return v - `PWM_DATA_W'(1);
	endfunction

	// bus decode: only the power register answers while the unit is off
	assign wr_power = req.wr && hit(req.addr, `PWM_OFF_POWER);
	assign acc_ok   = power_reg; // R14
	assign wr_any   = req.wr && acc_ok; // R14

	// channel and level writes, all gated by the power enable
	assign wr_start = wr_any && hit(req.addr, `PWM_OFF_START);
	assign wr_stop  = wr_any && hit(req.addr, `PWM_OFF_STOP);
	assign wr_level = wr_any && hit(req.addr, `PWM_OFF_OUTCTRL) && !req.wdata[`PWM_BIT_OUT_ENABLE]; // R18

	// trigger bits act as one-cycle pulses and never store
	assign period_start_trigger = wr_start && req.wdata[`PWM_BIT_MASTER]; // R20
	assign duty_start_trigger   = wr_start && req.wdata[`PWM_BIT_SLAVE]; // R20
	assign period_stop_trigger  = wr_stop && req.wdata[`PWM_BIT_MASTER]; // R20
	assign duty_stop_trigger    = wr_stop && req.wdata[`PWM_BIT_SLAVE]; // R20

	// count clock enables
	pwm_prescaler u_prescaler (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.run     (power_reg),
		.sel_a   (prescaler_select_reg[`PWM_SEL_W-1:0]),
		.sel_b   (prescaler_select_reg[2*`PWM_SEL_W-1:`PWM_SEL_W]),
		.tick_a  (tick_a),
		.tick_b  (tick_b)
	);

	// one count clock chosen from the two prescaled clocks
	assign count_en = channel_mode_reg ? tick_b : tick_a; // R15

	// master interval timer; a stop in the same cycle freezes the count at once
	assign master_zero = (period_counter == '0);
	assign master_step = channel_running_flag[`PWM_BIT_MASTER] && !period_stop_trigger && count_en; // R7 R21
	assign master_tick = period_start_trigger || (master_step && master_zero); // R5 R6 R7

	// the start tick loads at once, later ticks reload at zero
	assign period_counter_next =
		master_tick ? period_reload_value : // R5 R6 R1
		master_step ? count_down(period_counter) : // R1
		period_counter; // R21

	// slave one-count timer; a tick reload wins over a count step
	assign slave_step = channel_running_flag[`PWM_BIT_SLAVE] && !duty_stop_trigger && count_en
		&& (slave_state_reg == SLAVE_COUNT) && !master_tick;
	assign slave_end  = slave_step && (duty_counter == '0); // R9 R11 R3
	assign slave_rise = slave_step && (duty_counter != '0); // R10 R4

	// a tick retriggers the duty counter only if the slave runs or starts with it
	assign slave_retrigger = master_tick && (channel_running_flag[`PWM_BIT_SLAVE] || duty_start_trigger); // R8

	// slave sequencer next state
	always_comb begin
		slave_state_next  = slave_state_reg;
		duty_counter_next = duty_counter;
		case (slave_state_reg)
			SLAVE_IDLE: begin
				if (slave_retrigger) begin
					duty_counter_next = duty_reload_value; // R8
					slave_state_next  = SLAVE_COUNT;
				end
			end
			SLAVE_COUNT: begin
				if (slave_retrigger) begin
					duty_counter_next = duty_reload_value; // R8 R4
				end else if (slave_end) begin
					slave_state_next = SLAVE_IDLE; // R9
				end else if (slave_rise) begin
					duty_counter_next = count_down(duty_counter); // R2
				end
			end
			default: begin
				slave_state_next = SLAVE_IDLE;
			end
		endcase
	end

	// output level: hardware drives it only in slave output mode with the output enabled
	// software sets the default level with the enable written low, so no edge races it
	assign hw_owns_level = out_ctrl_reg.enable && out_ctrl_reg.slave_mode; // R16
	assign level_next =
		wr_level ?
			req.wdata[`PWM_BIT_OUT_LEVEL] : // R18
		(hw_owns_level && slave_rise) ? !out_ctrl_reg.polarity : // R10 R22
		(hw_owns_level && slave_end) ? out_ctrl_reg.polarity : // R11 R22
		level_reg; // R19 R21

	// port cell: latch ors onto the level, direction enables the driver
	assign pin.level = level_reg | port_reg[`PWM_BIT_PORT_LATCH]; // R18
	assign pin.oe    = port_reg[`PWM_BIT_PORT_DIR]; // R17
	assign pwm_out   = pin.level;
	assign pwm_oe    = pin.oe;

	// events leave as one-cycle pulses
	assign period_tick_irq = master_tick; // R5 R6
	assign duty_end_irq    = slave_end; // R9

	// read mux; blocked reads and unmapped offsets return zero
	assign rdata_next =
		!req.rd ? '0 :
		hit(req.addr, `PWM_OFF_POWER) ? `PWM_DATA_W'(power_reg) :
		!acc_ok ? '0 : // R14
		hit(req.addr, `PWM_OFF_PRESCALE) ? `PWM_DATA_W'(prescaler_select_reg) :
		hit(req.addr, `PWM_OFF_MODE) ? `PWM_DATA_W'(channel_mode_reg) :
		hit(req.addr, `PWM_OFF_OUTCTRL) ? {12'h000, level_reg,
			out_ctrl_reg.enable, out_ctrl_reg.polarity, out_ctrl_reg.slave_mode} : // R19
		hit(req.addr, `PWM_OFF_STATUS) ? `PWM_DATA_W'(channel_running_flag) :
		hit(req.addr, `PWM_OFF_PERIOD) ? period_reload_value :
		hit(req.addr, `PWM_OFF_DUTY) ? duty_reload_value :
		hit(req.addr, `PWM_OFF_PCOUNT) ? period_counter :
		hit(req.addr, `PWM_OFF_DCOUNT) ? duty_counter :
		hit(req.addr, `PWM_OFF_PORT) ? `PWM_DATA_W'(port_reg) :
		'0; // R20

	// read data leave straight from a flop, zero outside the answer cycle
	assign rdata = rdata_reg;

	// power enable register, the only one reachable while the unit is off
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			power_reg <= 1'b0;
		end else if (wr_power) begin
			power_reg <= req.wdata[`PWM_BIT_POWER]; // R14
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// configuration registers; power off loads their reset values
	always_ff @(posedge ref_clk) begin
		if (!resetn || !power_reg) begin
			prescaler_select_reg <= `PWM_RST_PRESCALE;
			channel_mode_reg     <= 1'b0;
			out_ctrl_reg         <= '0;
			port_reg             <= 2'h0;
			period_reload_value  <= `PWM_RST_RELOAD;
			duty_reload_value    <= `PWM_RST_RELOAD;
		end else if (wr_any) begin
			case (req.addr)
				`PWM_OFF_PRESCALE: prescaler_select_reg <= req.wdata[2*`PWM_SEL_W-1:0]; // R15
				`PWM_OFF_MODE:     channel_mode_reg     <= req.wdata[`PWM_BIT_CLKSEL];
				`PWM_OFF_OUTCTRL:  out_ctrl_reg         <= req.wdata[3:0]; // R16 R22
				`PWM_OFF_PORT:     port_reg             <= req.wdata[1:0]; // R17
				`PWM_OFF_PERIOD:   period_reload_value  <= req.wdata; // R12
				`PWM_OFF_DUTY:     duty_reload_value    <= req.wdata; // R12
				default: begin
				end
			endcase
		end
	end

	// running flags: start sets, stop clears, power off stops all channels
	always_ff @(posedge ref_clk) begin
		if (!resetn || !power_reg) begin
			channel_running_flag <= 2'b00; // R14
		end else begin
			if (period_stop_trigger) begin
				channel_running_flag[`PWM_BIT_MASTER] <= 1'b0; // R7 R21
			end else if (period_start_trigger) begin
				channel_running_flag[`PWM_BIT_MASTER] <= 1'b1; // R5
			end
			if (duty_stop_trigger) begin
				channel_running_flag[`PWM_BIT_SLAVE] <= 1'b0; // R21
			end else if (duty_start_trigger) begin
				channel_running_flag[`PWM_BIT_SLAVE] <= 1'b1;
			end
		end
	end

	// counters, sequencer and output level
	always_ff @(posedge ref_clk) begin
		if (!resetn || !power_reg) begin
			period_counter  <= `PWM_RST_COUNT;
			duty_counter    <= `PWM_RST_COUNT;
			slave_state_reg <= SLAVE_IDLE;
			level_reg       <= 1'b0;
		end else begin
			period_counter  <= period_counter_next;
			duty_counter    <= duty_counter_next;
			slave_state_reg <= slave_state_next;
			level_reg       <= level_next;
		end
	end

endmodule

// *** hw/pwm_defs.svh ***
// register offsets, field positions, reset values and bus and prescaler widths of the paired channel pwm
// assumes inclusion by bare name from the package and the design modules
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// bus widths
`define PWM_ADDR_W          4
`define PWM_DATA_W          16

// register offsets
`define PWM_OFF_POWER       4'h0
`define PWM_OFF_PRESCALE    4'h1
`define PWM_OFF_MODE        4'h2
`define PWM_OFF_OUTCTRL     4'h3
`define PWM_OFF_START       4'h4
`define PWM_OFF_STOP        4'h5
`define PWM_OFF_STATUS      4'h6
`define PWM_OFF_PERIOD      4'h7
`define PWM_OFF_DUTY        4'h8
`define PWM_OFF_PCOUNT      4'h9
`define PWM_OFF_DCOUNT      4'ha
`define PWM_OFF_PORT        4'hb

// field positions
`define PWM_BIT_POWER       0
`define PWM_BIT_CLKSEL      0
`define PWM_BIT_SLAVE_MODE  0
`define PWM_BIT_POLARITY    1
`define PWM_BIT_OUT_ENABLE  2
`define PWM_BIT_OUT_LEVEL   3
`define PWM_BIT_MASTER      0
`define PWM_BIT_SLAVE       1
`define PWM_BIT_PORT_DIR    0
`define PWM_BIT_PORT_LATCH  1

// reset values
`define PWM_RST_PRESCALE    8'h00
`define PWM_RST_RELOAD      16'hffff
`define PWM_RST_COUNT       16'hffff

// prescaler
`define PWM_PRE_W           16
`define PWM_SEL_W           4

`endif

// *** hw/pwm_pkg.sv ***
// types shared by the paired channel pwm modules
// assumes pwm_defs.svh is on the include path
`include "pwm_defs.svh"

package pwm_pkg;

	// slave channel sequencer, one-hot
	typedef enum logic [1:0] {
		SLAVE_IDLE  = 2'b01,
		SLAVE_COUNT = 2'b10
	} slave_state_e;

	// output control bits of the slave channel
	typedef struct packed {
		logic level;
		logic enable;
		logic polarity;
		logic slave_mode;
	} out_ctrl_s;

	// pin group: level and enable of the tri-state output
	typedef struct packed {
		logic level;
		logic oe;
	} pin_s;

	// register bus request
	typedef struct packed {
		logic [`PWM_ADDR_W-1:0] addr;
		logic [`PWM_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} bus_req_s;

endpackage

// *** hw/pwm_prescaler.sv ***
// two count clock enables derived from ref_clk by a power-of-two divider
// assumes one clock domain; run low holds the divider at zero
`timescale 1ns/10ps
`include "pwm_defs.svh"

module pwm_prescaler
	import pwm_pkg::*;
(
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	// control
	input  wire logic                  run,
	input  wire logic [`PWM_SEL_W-1:0] sel_a,
	input  wire logic [`PWM_SEL_W-1:0] sel_b,
	// enables
	output logic                       tick_a,
	output logic                       tick_b
);

	logic [`PWM_PRE_W-1:0] div_reg;
	logic [`PWM_PRE_W-1:0] div_next;

	// true on the last cycle of each 2^sel window
	// run comes in as an argument so that a change of run alone re-evaluates the callers
	function automatic logic tick_at(input logic en, input logic [`PWM_PRE_W-1:0] cnt,
		input logic [`PWM_SEL_W-1:0] sel);
		logic [`PWM_PRE_W-1:0] mask;
		mask = (`PWM_PRE_W'(1) << sel) - `PWM_PRE_W'(1);
		return en && ((cnt & mask) == mask);
	endfunction

	// free-running divider while the unit has power
	assign div_next = run ? div_reg + `PWM_PRE_W'(1) : '0;
	assign tick_a   = tick_at(run, div_reg, sel_a); // R15
	assign tick_b   = tick_at(run, div_reg, sel_b); // R15

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

endmodule

// *** testbench/pwm_checker.sv ***
// checker for the paired channel pwm top ports
// assumes one clock domain and binding onto paired_channel_pwm
`timescale 1ns/10ps
`include "pwm_defs.svh"

module pwm_checker
	import pwm_pkg::*;
(
	// clock and reset
	input wire logic                   ref_clk,
	input wire logic                   resetn,
	// register port
	input wire logic [`PWM_ADDR_W-1:0] addr,
	input wire logic [`PWM_DATA_W-1:0] wdata,
	input wire logic                   wr,
	input wire logic                   rd,
	input wire logic [`PWM_DATA_W-1:0] rdata,
	// events and pin
	input wire logic                   period_tick_irq,
	input wire logic                   duty_end_irq,
	input wire logic                   pwm_out,
	input wire logic                   pwm_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	logic pwr_reg;
	logic stop_reg;

	// bus decodes
	wire wr_pwr   = wr && addr == `PWM_OFF_POWER;
	wire wr_start = wr && addr == `PWM_OFF_START;
	wire wr_stop  = wr && addr == `PWM_OFF_STOP && wdata[1:0] == 2'b11;
	wire rd_trig  = rd && (addr == `PWM_OFF_START || addr == `PWM_OFF_STOP);

	// power and stopped state as seen from the bus
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pwr_reg  <= 1'b0;
			stop_reg <= 1'b1;
		end else begin
			if (wr_pwr)
				pwr_reg <= wdata[0];
			if (!pwr_reg || wr_stop)
				stop_reg <= 1'b1;
			else if (wr_start && |wdata[1:0])
				stop_reg <= 1'b0;
		end
	end

	a_start_tick: assert property (pwr_reg && wr_start && wdata[0] |-> period_tick_irq)
		else $error("no tick on master start");
	a_off_quiet: assert property (!pwr_reg |-> !period_tick_irq && !duty_end_irq)
		else $error("event while powered off");
	a_off_read: assert property (!pwr_reg && rd && !wr_pwr && addr != 4'h0 |=> rdata == '0)
		else $error("read data while powered off");
	a_trig_read: assert property (rd_trig |=> rdata == '0)
		else $error("trigger bits read nonzero");
	a_dir_oe: assert property (pwr_reg && wr && addr == `PWM_OFF_PORT |=> pwm_oe == $past(wdata[0]))
		else $error("pin enable not following direction");
	a_oe_hold: assert property (!wr |=> $stable(pwm_oe))
		else $error("pin enable moved without a write");
	a_stop_quiet: assert property (stop_reg && !wr |-> !period_tick_irq && !duty_end_irq)
		else $error("event while stopped");
	a_stop_hold: assert property (stop_reg && !wr |=> $stable(pwm_out))
		else $error("output moved while stopped");

	c_tick: cover property (period_tick_irq && !wr);
	c_end: cover property (duty_end_irq);
	c_drive: cover property (pwm_oe && pwm_out);
endmodule

bind paired_channel_pwm pwm_checker chk (.ref_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
	.period_tick_irq, .duty_end_irq, .pwm_out, .pwm_oe);

// *** testbench/pwm_load.sv ***
// external load on the pwm pin
// assumes a pull-up holds the pin high whenever the block releases it
`timescale 1ns/10ps

module pwm_load (
	// pin from the block
	input  wire logic pwm_out,
	input  wire logic pwm_oe,
	// level seen at the load
	output logic      pin_level
);
	// released pin floats to the pull-up level
	assign pin_level = pwm_oe ? pwm_out : 1'b1;
endmodule

// *** testbench/paired_channel_pwm_tb.sv ***
// self-checking bench for the paired channel pwm
// assumes the checker is bound and the load model resolves the pin
`timescale 1ns/10ps
`include "pwm_defs.svh"

module paired_channel_pwm_tb
	import pwm_pkg::*;
;
	logic        ref_clk;
	logic        resetn;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        period_tick_irq;
	logic        duty_end_irq;
	logic        pwm_out;
	logic        pwm_oe;
	logic        pin_level;
	int          n_fail;
	int          n_checks;

	paired_channel_pwm DUT (.ref_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
		.period_tick_irq, .duty_end_irq, .pwm_out, .pwm_oe);
	pwm_load load (.pwm_out, .pwm_oe, .pin_level);

	// 250 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic print_verdict();
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one write cycle, then one idle cycle
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr    <= 1'b0;
		@(posedge ref_clk);
	endtask

	// one read cycle, data taken in the next cycle
	task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd   <= 1'b0;
		@(negedge ref_clk);
		chk(what, exp, rdata);
		@(posedge ref_clk);
	endtask

	// access blocked while off, reset values once on
	task automatic t_power();
		wreg(`PWM_OFF_PERIOD, 16'h0012);
		rchk(`PWM_OFF_PERIOD, 16'h0000, "period off");
		wreg(`PWM_OFF_POWER, 16'h0001);
		rchk(`PWM_OFF_PERIOD, `PWM_RST_RELOAD, "period rst");
		rchk(`PWM_OFF_DCOUNT, `PWM_RST_COUNT, "dcount rst");
		rchk(`PWM_OFF_STATUS, 16'h0000, "status rst");
		rchk(4'hc, 16'h0000, "unmapped");
	endtask

	// pin released until the port direction is set
	task automatic t_pin();
		wreg(`PWM_OFF_OUTCTRL, 16'h0001);
		chk("pin float", 16'h0001, 16'(pin_level));
		wreg(`PWM_OFF_PORT, 16'h0001);
		chk("pin low", 16'h0000, 16'(pin_level));
		wreg(`PWM_OFF_PORT, 16'h0003);
		chk("pin latch", 16'h0001, 16'(pin_level));
		rchk(`PWM_OFF_PORT, 16'h0003, "port rd");
		wreg(`PWM_OFF_PORT, 16'h0001);
		wreg(`PWM_OFF_OUTCTRL, 16'h0009);
		chk("pin high", 16'h0001, 16'(pin_level));
		rchk(`PWM_OFF_OUTCTRL, 16'h0009, "outctrl rd");
	endtask

	// bounded wait for the next master tick
	task automatic wait_tick();
		for (int i = 0; i < 200; i++) begin
			@(negedge ref_clk);
			if (period_tick_irq === 1'b1)
				return;
		end
		n_fail++;
		print_verdict();
	endtask

	// run one setting, measure a steady period, then stop
	task automatic t_pwm(input logic [15:0] m, d, oc, pre, md, per, hi);
		logic [15:0] np, nh, ne, nb, sw, c0;
		logic        lv, de;
		// reloads written while stopped, upper byte zero
		wreg(`PWM_OFF_PRESCALE, pre);
		wreg(`PWM_OFF_MODE, md);
		wreg(`PWM_OFF_PERIOD, m);
		wreg(`PWM_OFF_DUTY, d);
		wreg(`PWM_OFF_OUTCTRL, oc);
		addr  <= `PWM_OFF_START;
		wdata <= 16'h0003;
		wr    <= 1'b1;
		@(negedge ref_clk);
		chk("start tick", 16'h0001, 16'(period_tick_irq));
		@(posedge ref_clk);
		wr <= 1'b0;
		wait_tick();
		wait_tick();
		lv = pwm_out;
		{np, nh, ne, nb, sw} = '0;
		for (int i = 0; i < 200; i++) begin
			nh += 16'(pwm_out);
			ne += 16'(duty_end_irq);
			de = duty_end_irq;
			np++;
			@(negedge ref_clk);
			if (np == 16'h0001)
				sw = 16'(pwm_out === lv);
			if (np == 16'h0002)
				sw = sw & 16'(pwm_out !== lv);
			if (de && pwm_out !== lv)
				nb++;
			if (period_tick_irq === 1'b1)
				break;
		end
		chk("period", per, np);
		chk("active", hi, nh);
		if (md == 16'h0000 && hi != 16'h0000 && hi != per) begin
			chk("rise", 16'h0001, sw);
			chk("ends", 16'h0001, ne);
			chk("fall", 16'h0000, nb);
		end
		@(posedge ref_clk);
		rchk(`PWM_OFF_STATUS, 16'h0003, "running");
		rchk(`PWM_OFF_START, 16'h0000, "start rd");
		wreg(`PWM_OFF_STOP, 16'h0003);
		rchk(`PWM_OFF_STATUS, 16'h0000, "stopped");
		rchk(`PWM_OFF_STOP, 16'h0000, "stop rd");
		lv = pwm_out;
		addr <= `PWM_OFF_PCOUNT;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(negedge ref_clk);
		c0 = rdata;
		repeat (20) @(posedge ref_clk);
		rchk(`PWM_OFF_PCOUNT, c0, "frozen");
		chk("held", 16'(lv), 16'(pwm_out));
	endtask

	initial begin
		resetn   = 1'b0;
		addr     = 4'h0;
		wdata    = 16'h0000;
		wr       = 1'b0;
		rd       = 1'b0;
		n_fail   = 0;
		n_checks = 0;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		t_power();
		t_pin();
		t_pwm(16'h0002, 16'h0001, 16'h0005, 16'h0000, 16'h0000, 16'h0003, 16'h0001);
		t_pwm(16'h0003, 16'h0000, 16'h0005, 16'h0000, 16'h0000, 16'h0004, 16'h0000);
		t_pwm(16'h0003, 16'h0004, 16'h0005, 16'h0000, 16'h0000, 16'h0004, 16'h0004);
		t_pwm(16'h0003, 16'h0009, 16'h0005, 16'h0000, 16'h0000, 16'h0004, 16'h0004);
		t_pwm(16'h0004, 16'h0001, 16'h0007, 16'h0000, 16'h0000, 16'h0005, 16'h0004);
		t_pwm(16'h0002, 16'h0001, 16'h0005, 16'h0010, 16'h0001, 16'h0006, 16'h0002);
		print_verdict();
	end
endmodule
